// ---- hw/spsq_host.sv ----
// Purpose: host end: rails, input clock, hard reset and stream control
// Assumes: rails are discharged when srst is released
// Notes:   one down-counter times every step of the sequence but the wait for standby
//
// What this block does
// - PLL rail comes up first, never later
// - Rails up in order, step gap between
// - Input clock starts after last rail settles
// - Hard reset held at least 1 ms
// - Sensor tri-states pixel pins during reset
// - Wait 150000 input clocks after reset release
// - Configure in standby, wait 1 ms lock
// - Stream enable bit set as last step
// - Sensor stops at row or frame end
// - Clear streaming, await standby before rails off
// - Rails off in reverse order, PLL last
// - Wait 100 ms before next power-up
`timescale 1ns/1ps
module spsq_host
  import spsq_pkg::*;
#(
  parameter int HARD_RST_CYCLES = HARD_RST_CYC,
  parameter int INIT_CYCLES     = INIT_CLKS,
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC,
  parameter int COOL_CYCLES     = COOL_DOWN_CYC
)(
  input  wire logic clk_sys,
  input  wire logic srst,
  spsq_if.host      link,
  input  wire logic up_req,
  input  wire logic down_req,
  input  wire logic stop_at_frame,
  output logic      seq_off,
  output logic      seq_streaming,
  output logic      seq_busy
);
  typedef enum logic [14:0] {
    H_IDLE = 15'h0001,
    H_PLL  = 15'h0002,
    H_ANA  = 15'h0004,
    H_IO   = 15'h0008,
    H_CORE = 15'h0010,
    H_SER  = 15'h0020,
    H_RST  = 15'h0040,
    H_INIT = 15'h0080,
    H_LOCK = 15'h0100,
    H_STRM = 15'h0200,
    H_STOP = 15'h0400,
    H_SOFF = 15'h0800,
    H_COFF = 15'h1000,
    H_IOFF = 15'h2000,
    H_AOFF = 15'h4000
  } spsq_hst_t;

  typedef struct packed {
    spsq_hst_t         st;
    logic [CNT_W-1:0]  cnt;
    logic              pll;
    logic              ana;
    logic              pix;
    logic              io;
    logic              core;
    logic              ser;
    logic              clk_en;
    logic              rst_n;
    logic              wr;
    logic [DATA_W-1:0] wdata;
    logic              frame;
  } spsq_hsq_t;

  localparam spsq_hsq_t HST_RST = '{st: H_IDLE, default: '0};
  localparam logic [CNT_W-1:0] GAP_LOAD = CNT_W'(STEP_GAP_CYC - 1);

  spsq_hsq_t cur_ff;
  spsq_hsq_t nxt_cur;
  logic      cnt_zero;

  assign cnt_zero = (cur_ff.cnt == '0);

  always_comb
  begin
    nxt_cur    = cur_ff;
    nxt_cur.wr = 1'b0;
    if (!cnt_zero)
      nxt_cur.cnt = cur_ff.cnt - 1'b1;
    case (cur_ff.st)
      H_IDLE:
      begin
        // Cool-down count still running blocks a new power-up
        if (up_req && cnt_zero)
        begin
          nxt_cur.pll   = 1'b1;
          nxt_cur.rst_n = 1'b0;
          nxt_cur.frame = stop_at_frame;
          nxt_cur.cnt   = GAP_LOAD;
          nxt_cur.st    = H_PLL;
        end
      end
      H_PLL:
      begin
        if (cnt_zero)
        begin
          nxt_cur.ana = 1'b1;
          nxt_cur.pix = 1'b1;
          nxt_cur.cnt = GAP_LOAD;
          nxt_cur.st  = H_ANA;
        end
      end
      H_ANA:
      begin
        if (cnt_zero)
        begin
          nxt_cur.io  = 1'b1;
          nxt_cur.cnt = GAP_LOAD;
          nxt_cur.st  = H_IO;
        end
      end
      H_IO:
      begin
        if (cnt_zero)
        begin
          nxt_cur.core = 1'b1;
          nxt_cur.cnt  = GAP_LOAD;
          nxt_cur.st   = H_CORE;
        end
      end
      H_CORE:
      begin
        if (cnt_zero)
        begin
          nxt_cur.ser = 1'b1;
          // One more gap lets the serial rail settle
          nxt_cur.cnt = GAP_LOAD;
          nxt_cur.st  = H_SER;
        end
      end
      H_SER:
      begin
        if (cnt_zero)
        begin
          nxt_cur.clk_en = 1'b1;
          nxt_cur.cnt    = CNT_W'(HARD_RST_CYCLES - 1);
          nxt_cur.st     = H_RST;
        end
      end
      H_RST:
      begin
        if (cnt_zero)
        begin
          nxt_cur.rst_n = 1'b1;
          nxt_cur.cnt   = CNT_W'(INIT_CYCLES);
          nxt_cur.st    = H_INIT;
        end
      end
      H_INIT:
      begin
        // No margin: the write lands in the first cycle of the sensor's standby, its S_OFF cycle using up the extra count
        if (cnt_zero)
        begin
          nxt_cur.wr    = 1'b1;
          nxt_cur.wdata = spsq_ctrl_word(1'b0, cur_ff.frame);
          nxt_cur.cnt   = CNT_W'(PLL_LOCK_CYCLES - 1);
          nxt_cur.st    = H_LOCK;
        end
      end
      H_LOCK:
      begin
        if (cnt_zero)
        begin
          nxt_cur.wr    = 1'b1;
          nxt_cur.wdata = spsq_ctrl_word(1'b1, cur_ff.frame);
          nxt_cur.st    = H_STRM;
        end
      end
      H_STRM:
      begin
        if (down_req)
        begin
          nxt_cur.wr    = 1'b1;
          nxt_cur.wdata = spsq_ctrl_word(1'b0, cur_ff.frame);
          nxt_cur.st    = H_STOP;
        end
      end
      H_STOP:
      begin
        // Standby may lag a whole frame; rails stay on until then
        if (link.soft_standby)
        begin
          nxt_cur.ser    = 1'b0;
          nxt_cur.clk_en = 1'b0;
          nxt_cur.rst_n  = 1'b0;
          nxt_cur.cnt    = GAP_LOAD;
          nxt_cur.st     = H_SOFF;
        end
      end
      H_SOFF:
      begin
        if (cnt_zero)
        begin
          nxt_cur.core = 1'b0;
          nxt_cur.cnt  = GAP_LOAD;
          nxt_cur.st   = H_COFF;
        end
      end
      H_COFF:
      begin
        if (cnt_zero)
        begin
          nxt_cur.io  = 1'b0;
          nxt_cur.cnt = GAP_LOAD;
          nxt_cur.st  = H_IOFF;
        end
      end
      H_IOFF:
      begin
        if (cnt_zero)
        begin
          nxt_cur.ana = 1'b0;
          nxt_cur.pix = 1'b0;
          nxt_cur.cnt = GAP_LOAD;
          nxt_cur.st  = H_AOFF;
        end
      end
      H_AOFF:
      begin
        if (cnt_zero)
        begin
          nxt_cur.pll = 1'b0;
          nxt_cur.cnt = CNT_W'(COOL_CYCLES - 1);
          nxt_cur.st  = H_IDLE;
        end
      end
      default:
        nxt_cur = HST_RST;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cur_ff <= HST_RST;
    else
      cur_ff <= nxt_cur;
  end

  assign link.rail_pll_en    = cur_ff.pll;
  assign link.rail_analog_en = cur_ff.ana;
  assign link.rail_pixel_en  = cur_ff.pix;
  assign link.rail_io_en     = cur_ff.io;
  assign link.rail_core_en   = cur_ff.core;
  assign link.rail_serial_en = cur_ff.ser;
  assign link.ext_clk_en     = cur_ff.clk_en;
  assign link.hard_reset_n   = cur_ff.rst_n;
  assign link.cfg_wr         = cur_ff.wr;
  assign link.cfg_addr       = CTRL_ADDR;
  assign link.cfg_wdata      = cur_ff.wdata;
  assign seq_off             = (cur_ff.st == H_IDLE) && cnt_zero;
  assign seq_streaming       = (cur_ff.st == H_STRM);
  assign seq_busy            = !seq_off && !seq_streaming;
endmodule : spsq_host

// ---- common/spsq_pkg.sv ----
// Purpose: shared constants for the sensor power/reset sequencer pair
// Assumes: one 25 MHz clock stands for the external input clock
// Notes:   times are kept in their own unit, cycle counts are derived
package spsq_pkg;
  localparam int CLK_MHZ        = 25;
  localparam int US_PER_MS      = 1000;
  localparam int STEP_GAP_US    = 100;
  localparam int HARD_RST_MS    = 1;
  localparam int PLL_LOCK_MS    = 1;
  localparam int COOL_DOWN_MS   = 100;
  localparam int INIT_CLKS      = 150000;
  localparam int STEP_GAP_CYC   = STEP_GAP_US * CLK_MHZ;
  localparam int HARD_RST_CYC   = HARD_RST_MS * US_PER_MS * CLK_MHZ;
  localparam int PLL_LOCK_CYC   = PLL_LOCK_MS * US_PER_MS * CLK_MHZ;
  localparam int COOL_DOWN_CYC  = COOL_DOWN_MS * US_PER_MS * CLK_MHZ;

  localparam int CNT_W          = 22;
  localparam int ADDR_W         = 16;
  localparam int DATA_W         = 16;
  localparam int PIX_W          = 10;

  localparam logic [ADDR_W-1:0] CTRL_ADDR      = 16'h301A;
  localparam int                STREAM_BIT     = 2;
  localparam int                STOP_FRAME_BIT = 4;
  localparam logic [DATA_W-1:0] CTRL_RST       = 16'h0000;

  // Test pattern geometry of the sensor model
  localparam int COL_W          = 5;
  localparam int ROW_W          = 3;
  localparam logic [COL_W-1:0] ROW_PIX    = 5'h10;
  localparam logic [COL_W-1:0] ROW_LAST   = 5'h13;
  localparam logic [ROW_W-1:0] FRAME_LAST = 3'h3;

  function automatic logic [DATA_W-1:0] spsq_ctrl_word(
    input logic stream,
    input logic frame
  );
    logic [DATA_W-1:0] w;
    w                 = CTRL_RST;
    w[STREAM_BIT]     = stream;
    w[STOP_FRAME_BIT] = frame;
    return w;
  endfunction : spsq_ctrl_word
endpackage : spsq_pkg

// ---- common/spsq_if.sv ----
// Purpose: board-level link between host sequencer and image sensor
// Assumes: rails and clock gate are modelled as enable levels
// Notes:   pixel bus level is resolved by the bench from pix_oe
`timescale 1ns/1ps
interface spsq_if;
  import spsq_pkg::*;
  logic              rail_pll_en;
  logic              rail_analog_en;
  logic              rail_pixel_en;
  logic              rail_io_en;
  logic              rail_core_en;
  logic              rail_serial_en;
  logic              ext_clk_en;
  logic              hard_reset_n;
  logic              cfg_wr;
  logic [ADDR_W-1:0] cfg_addr;
  logic [DATA_W-1:0] cfg_wdata;
  logic [PIX_W-1:0]  pix_data;
  logic              pix_oe;
  logic              line_valid;
  logic              frame_valid;
  logic              soft_standby;

  modport host (
    output rail_pll_en, rail_analog_en, rail_pixel_en, rail_io_en,
    output rail_core_en, rail_serial_en, ext_clk_en, hard_reset_n,
    output cfg_wr, cfg_addr, cfg_wdata,
    input  pix_data, pix_oe, line_valid, frame_valid, soft_standby
  );
  modport sensor (
    input  rail_pll_en, rail_analog_en, rail_pixel_en, rail_io_en,
    input  rail_core_en, rail_serial_en, ext_clk_en, hard_reset_n,
    input  cfg_wr, cfg_addr, cfg_wdata,
    output pix_data, pix_oe, line_valid, frame_valid, soft_standby
  );
endinterface : spsq_if

// ---- hw/spsq_sensor.sv ----
// Purpose: sensor end: reset, initialisation, stream start and stop
// Assumes: clk_sys stands for the external input clock when gated on
// Notes:   pixel data is a row/column test pattern
`timescale 1ns/1ps
module spsq_sensor
  import spsq_pkg::*;
#(
  parameter int INIT_CYCLES = INIT_CLKS
)(
  input  wire logic clk_sys,
  input  wire logic srst,
  spsq_if.sensor    link,
  output logic      init_busy,
  output logic      streaming
);
  typedef enum logic [4:0] {
    S_OFF  = 5'h01,
    S_INIT = 5'h02,
    S_STBY = 5'h04,
    S_STRM = 5'h08,
    S_STOP = 5'h10
  } spsq_sst_t;

  typedef struct packed {
    spsq_sst_t         st;
    logic [CNT_W-1:0]  cnt;
    logic              stream_en;
    logic              stop_frame;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
    logic [PIX_W-1:0]  pix;
    logic              oe;
    logic              lv;
    logic              fv;
  } spsq_sen_t;

  localparam spsq_sen_t SEN_RST = '{st: S_OFF, default: '0};

  spsq_sen_t cur_ff;
  spsq_sen_t nxt_cur;
  logic      powered;
  logic      row_end;

  assign powered = link.rail_pll_en & link.rail_analog_en &
                   link.rail_pixel_en & link.rail_io_en &
                   link.rail_core_en & link.rail_serial_en;
  assign row_end = (cur_ff.col == ROW_LAST);

  always_comb
  begin
    nxt_cur = cur_ff;
    if (!powered || !link.hard_reset_n)
    begin
      nxt_cur = SEN_RST;
    end
    else if (link.ext_clk_en)
    begin
      nxt_cur.oe = 1'b1;
      // Writes before standby are lost, as the core is not yet up
      if (link.cfg_wr && link.cfg_addr == CTRL_ADDR &&
          cur_ff.st != S_OFF && cur_ff.st != S_INIT)
      begin
        nxt_cur.stream_en  = link.cfg_wdata[STREAM_BIT];
        nxt_cur.stop_frame = link.cfg_wdata[STOP_FRAME_BIT];
      end
      case (cur_ff.st)
        S_OFF:
        begin
          nxt_cur.st  = S_INIT;
          nxt_cur.cnt = CNT_W'(INIT_CYCLES - 1);
        end
        S_INIT:
        begin
          if (cur_ff.cnt == '0)
            nxt_cur.st = S_STBY;
          else
            nxt_cur.cnt = cur_ff.cnt - 1'b1;
        end
        S_STBY:
        begin
          nxt_cur.col = '0;
          nxt_cur.row = '0;
          if (cur_ff.stream_en)
            nxt_cur.st = S_STRM;
        end
        S_STRM, S_STOP:
        begin
          nxt_cur.col = row_end ? '0 : cur_ff.col + 1'b1;
          if (row_end)
            nxt_cur.row = cur_ff.row + 1'b1;
          if (row_end && cur_ff.row == FRAME_LAST)
            nxt_cur.row = '0;
          if (cur_ff.st == S_STRM && !cur_ff.stream_en)
            nxt_cur.st = S_STOP;
          if (cur_ff.st == S_STOP && row_end &&
              (!cur_ff.stop_frame || cur_ff.row == FRAME_LAST))
            nxt_cur.st = S_STBY;
        end
        default:
          nxt_cur.st = S_OFF;
      endcase
      nxt_cur.fv  = (cur_ff.st == S_STRM) || (cur_ff.st == S_STOP);
      nxt_cur.lv  = nxt_cur.fv && (cur_ff.col < ROW_PIX);
      nxt_cur.pix = nxt_cur.lv ? PIX_W'({cur_ff.row, cur_ff.col}) : '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      cur_ff <= SEN_RST;
    else
      cur_ff <= nxt_cur;
  end

  assign link.pix_data     = cur_ff.pix;
  // Gated by the live reset level so the bus floats in the first cycle
  assign link.pix_oe       = cur_ff.oe & powered & link.hard_reset_n;
  assign link.line_valid   = cur_ff.lv;
  assign link.frame_valid  = cur_ff.fv;
  assign link.soft_standby = (cur_ff.st == S_STBY);
  assign init_busy         = (cur_ff.st == S_INIT);
  assign streaming         = (cur_ff.st == S_STRM);
endmodule : spsq_sensor

// ---- dv/spsq_chk.sv ----
// Purpose: concurrent checks on the host to sensor power link
// Assumes: one clock, srst synchronous and active high
// Notes:   lock and cool-down counters saturate so a long cool-down costs nothing
`timescale 1ns/1ps
module spsq_chk
  import spsq_pkg::*;
#(
  parameter int HARD_RST_CYCLES = HARD_RST_CYC,
  parameter int PLL_LOCK_CYCLES = PLL_LOCK_CYC,
  parameter int COOL_CYCLES     = COOL_DOWN_CYC
)(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              rail_pll_en,
  input  wire logic              rail_analog_en,
  input  wire logic              rail_pixel_en,
  input  wire logic              rail_io_en,
  input  wire logic              rail_core_en,
  input  wire logic              rail_serial_en,
  input  wire logic              ext_clk_en,
  input  wire logic              hard_reset_n,
  input  wire logic              cfg_wr,
  input  wire logic [ADDR_W-1:0] cfg_addr,
  input  wire logic [DATA_W-1:0] cfg_wdata,
  input  wire logic              pix_oe,
  input  wire logic              line_valid,
  input  wire logic              soft_standby
);
  localparam int CAP = 32'h00FFFFFF;
  int   rst_cnt_ff;
  int   lock_cnt_ff;
  int   cool_cnt_ff;
  logic in_init_ff;

  // Host assumes discharged rails at srst, so cool-down starts full
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      rst_cnt_ff  <= 0;
      lock_cnt_ff <= 0;
      cool_cnt_ff <= CAP;
      in_init_ff  <= 1'b1;
    end
    else
    begin
      rst_cnt_ff  <= !rail_serial_en ? 0 : rst_cnt_ff + int'(!hard_reset_n);
      lock_cnt_ff <= (cfg_wr && !cfg_wdata[STREAM_BIT]) ? 0 :
                     (lock_cnt_ff < CAP ? lock_cnt_ff + 1 : CAP);
      cool_cnt_ff <= rail_pll_en ? 0 :
                     (cool_cnt_ff < CAP ? cool_cnt_ff + 1 : CAP);
      in_init_ff  <= !hard_reset_n ? 1'b1 : (soft_standby ? 1'b0 : in_init_ff);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  property p_pll_first;
    (rail_analog_en || rail_pixel_en || rail_io_en || rail_core_en ||
     rail_serial_en) |-> rail_pll_en;
  endproperty
  a_pll_first: assert property (p_pll_first)
    else $error("rail on while pll rail off");
  property p_clk_rails;
    ext_clk_en |-> $past(rail_serial_en);
  endproperty
  a_clk_rails: assert property (p_clk_rails)
    else $error("input clock before last rail");
  property p_rst_hold;
    $rose(hard_reset_n) |-> rst_cnt_ff >= HARD_RST_CYCLES && ext_clk_en;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("hard reset released early");
  property p_tristate;
    !hard_reset_n |-> !pix_oe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("pixel bus driven in reset");
  property p_cfg_wait;
    cfg_wr |-> (!in_init_ff || soft_standby) && cfg_addr == CTRL_ADDR;
  endproperty
  a_cfg_wait: assert property (p_cfg_wait)
    else $error("config write before standby");
  property p_lock;
    cfg_wr && cfg_wdata[STREAM_BIT] |-> lock_cnt_ff >= PLL_LOCK_CYCLES - 1;
  endproperty
  a_lock: assert property (p_lock)
    else $error("stream enabled before lock wait");
  property p_stop;
    cfg_wr && !cfg_wdata[STREAM_BIT] |-> ##[1:200] soft_standby;
  endproperty
  a_stop: assert property (p_stop)
    else $error("standby not reached after stop");
  property p_row_whole;
    $fell(line_valid) |-> $past(line_valid, 16) && !$past(line_valid, 17);
  endproperty
  a_row_whole: assert property (p_row_whole)
    else $error("row cut short");
  property p_down_standby;
    $fell(rail_serial_en) |-> $past(soft_standby);
  endproperty
  a_down_standby: assert property (p_down_standby)
    else $error("rail off before standby");
  property p_down_order;
    (!rail_core_en |-> !rail_serial_en) and (!rail_io_en |-> !rail_core_en)
    and (!(rail_analog_en && rail_pixel_en) |-> !rail_io_en);
  endproperty
  a_down_order: assert property (p_down_order)
    else $error("rails out of order");
  property p_cool;
    $rose(rail_pll_en) |-> cool_cnt_ff >= COOL_CYCLES - 1;
  endproperty
  a_cool: assert property (p_cool)
    else $error("power-up too soon after power-down");

  c_stream: cover property (cfg_wr && cfg_wdata[STREAM_BIT]);
  c_frame_stop: cover property (cfg_wr && cfg_wdata[STOP_FRAME_BIT]);
  c_down: cover property ($fell(rail_serial_en));
endmodule : spsq_chk

// ---- dv/spsq_bench.sv ----
// Purpose: power-up and power-down runs of host and sensor together
// Assumes: long counts shortened by parameters, step gap kept
// Notes:   edge times are logged on the falling clock edge
`timescale 1ns/1ps
module spsq_bench;
  import spsq_pkg::*;
  localparam int HR   = 20;
  localparam int INI  = 50;
  localparam int PL   = 20;
  localparam int CL   = 30;
  localparam int G    = STEP_GAP_CYC;
  localparam int CEIL = 60000;
  logic             clk_sys = 1'b0;
  logic             srst = 1'b1;
  logic             up_req = 1'b0;
  logic             down_req = 1'b0;
  logic             stop_at_frame = 1'b0;
  logic             seq_off;
  logic             seq_streaming;
  logic             seq_busy;
  logic             init_busy;
  logic             streaming;
  logic [10:0]      sigv;
  logic [10:0]      prev_ff = '0;
  logic [PIX_W-1:0] last_pix = '0;
  logic             fv_seen = 1'b0;
  int               num_errors = 0;
  int               tests_run = 0;
  int               cyc = 0;
  int               t0 = 0;
  int               t_rise[11];
  int               t_fall[11];

  spsq_if spsq_if_i ();
  spsq_host #(.HARD_RST_CYCLES(HR), .INIT_CYCLES(INI),
    .PLL_LOCK_CYCLES(PL), .COOL_CYCLES(CL)) spsq_host_i (
    .clk_sys(clk_sys), .srst(srst), .link(spsq_if_i.host),
    .up_req(up_req), .down_req(down_req), .stop_at_frame(stop_at_frame),
    .seq_off(seq_off), .seq_streaming(seq_streaming), .seq_busy(seq_busy));
  spsq_sensor #(.INIT_CYCLES(INI)) spsq_sensor_i (
    .clk_sys(clk_sys), .srst(srst), .link(spsq_if_i.sensor),
    .init_busy(init_busy), .streaming(streaming));
  spsq_chk #(.HARD_RST_CYCLES(HR), .PLL_LOCK_CYCLES(PL),
    .COOL_CYCLES(CL)) spsq_chk_i (
    .clk_sys(clk_sys), .srst(srst),
    .rail_pll_en(spsq_if_i.rail_pll_en),
    .rail_analog_en(spsq_if_i.rail_analog_en),
    .rail_pixel_en(spsq_if_i.rail_pixel_en),
    .rail_io_en(spsq_if_i.rail_io_en),
    .rail_core_en(spsq_if_i.rail_core_en),
    .rail_serial_en(spsq_if_i.rail_serial_en),
    .ext_clk_en(spsq_if_i.ext_clk_en),
    .hard_reset_n(spsq_if_i.hard_reset_n), .cfg_wr(spsq_if_i.cfg_wr),
    .cfg_addr(spsq_if_i.cfg_addr), .cfg_wdata(spsq_if_i.cfg_wdata),
    .pix_oe(spsq_if_i.pix_oe), .line_valid(spsq_if_i.line_valid),
    .soft_standby(spsq_if_i.soft_standby));

  assign sigv = {seq_off, seq_streaming, spsq_if_i.soft_standby,
    spsq_if_i.hard_reset_n, spsq_if_i.ext_clk_en, spsq_if_i.rail_serial_en,
    spsq_if_i.rail_core_en, spsq_if_i.rail_io_en, spsq_if_i.rail_pixel_en,
    spsq_if_i.rail_analog_en, spsq_if_i.rail_pll_en};

  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc >= CEIL)
    begin
      num_errors++;
      end_of_test();
    end
  end

  always @(negedge clk_sys)
  begin
    for (int i = 0; i < 11; i++)
    begin
      if (sigv[i] === 1'b1 && prev_ff[i] !== 1'b1)
        t_rise[i] = cyc;
      if (sigv[i] !== 1'b1 && prev_ff[i] === 1'b1)
        t_fall[i] = cyc;
    end
    prev_ff = sigv;
    if (spsq_if_i.line_valid === 1'b1 && spsq_if_i.pix_oe === 1'b1)
      last_pix = spsq_if_i.pix_data;
    if (spsq_if_i.frame_valid === 1'b1)
      fv_seen = 1'b1;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait; a stuck level shows up in the caller's compare
  task automatic wait_bit(input int b, input logic v);
    for (int n = 0; n < 20000 && sigv[b] !== v; n++)
      @(negedge clk_sys);
    // Lets the edge logger record this negedge before callers read it
    @(posedge clk_sys);
  endtask : wait_bit

  task automatic pulse(input logic dn);
    @(posedge clk_sys);
    if (dn)
      down_req <= 1'b1;
    else
      up_req <= 1'b1;
    @(posedge clk_sys);
    down_req <= 1'b0;
    up_req <= 1'b0;
    @(negedge clk_sys);
    t0 = cyc;
  endtask : pulse

  // Rail step index: pll, analog, pixel, io, core, serial, clock, reset
  function automatic int step(input int i);
    return (i == 0) ? 0 : (i < 3) ? 1 : (i < 6) ? i - 1 : 5;
  endfunction : step

  task automatic power_up(input logic frm);
    int tu;
    @(posedge clk_sys);
    stop_at_frame <= frm;
    pulse(1'b0);
    tu = t0;
    fv_seen = 1'b0;
    // Power-down request mid bring-up must be ignored
    pulse(1'b1);
    check(seq_busy, 1'b1);
    wait_bit(9, 1'b1);
    for (int i = 0; i < 10; i++)
      if (i != 8)
        check(t_rise[i] - tu, step(i) * G + (i >= 7 ? HR : 0) +
              (i == 9 ? INI + 1 + PL : 0));
    check(t_rise[0] < t_rise[1], 1'b1);
    check(t_rise[8] < t_rise[9], 1'b1);
    repeat (200) @(negedge clk_sys);
    check({fv_seen, streaming, spsq_if_i.pix_oe}, 3'h7);
    $display("test power_up stop_at_frame=%0d done", frm);
  endtask : power_up

  task automatic power_down(input logic frm);
    pulse(1'b1);
    wait_bit(5, 1'b0);
    check(t_fall[5] - t_rise[8], 1);
    check(last_pix[4:0], ROW_PIX - 1);
    if (frm)
      check(last_pix[7:5], FRAME_LAST);
    wait_bit(0, 1'b0);
    for (int i = 0; i < 8; i++)
      check(t_fall[i] - t_fall[5], i < 6 ? (4 - step(i)) * G : 0);
    check(spsq_if_i.pix_oe, 1'b0);
    $display("test power_down stop_at_frame=%0d done", frm);
  endtask : power_down

  initial
  begin
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    check(sigv, 11'h400);
    $display("test reset_state done");
    power_up(1'b0);
    power_down(1'b0);
    // Power-up request during cool-down must be ignored
    pulse(1'b0);
    repeat (4) @(negedge clk_sys);
    check(spsq_if_i.rail_pll_en, 1'b0);
    $display("test cool_down done");
    wait_bit(10, 1'b1);
    power_up(1'b1);
    check(t_rise[0] - t_fall[0] >= CL, 1'b1);
    power_down(1'b1);
    end_of_test();
  end
endmodule : spsq_bench
